//--- src/fpr_pkg.sv
package fpr_pkg;

   // Clock and power-on timing
   localparam int MCLK_MHZ     = 200;
   localparam int MCLK_NS      = 5;
   localparam int T_VTR_US     = 100;
   localparam int T_DTW_US     = 500;
   localparam int T_VTW_US     = 600;
   localparam int T_DESEL_NS   = 50;
   localparam int VTR_CYC      = T_VTR_US * MCLK_MHZ;
   localparam int DTW_CYC      = T_DTW_US * MCLK_MHZ;
   localparam int VTW_CYC      = T_VTW_US * MCLK_MHZ;
   localparam int DESEL_CYC    = (T_DESEL_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int SCLK_HALF    = 12;

   // Instruction codes
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_READ_FLAG   = 8'h70;
   localparam logic [7:0] OP_WRITE_EN    = 8'h06;
   localparam logic [7:0] OP_WRITE_NVCR  = 8'hB1;
   localparam logic [7:0] OP_WRITE_VCR   = 8'h81;
   localparam logic [7:0] OP_READ        = 8'h03;

   // Frame lengths in clocks
   localparam int LEN_CMD      = 8;
   localparam int LEN_POLL     = 16;
   localparam int LEN_VCR      = 16;
   localparam int LEN_NVCR     = 24;
   localparam int LEN_RD_DATA  = 32;
   localparam int LEN_READ     = 40;
   localparam int LEN_RESCUE0  = 7;
   localparam int LEN_RESCUE1  = 13;
   localparam int LEN_RESCUE2  = 25;
   localparam int LEN_RESCUE3  = 8;

   // Register fields and delivered contents
   localparam int NVCR_FAST_POR_BIT = 5;
   localparam int NVCR_XIP_LSB      = 9;
   localparam int NVCR_XIP_MSB      = 11;
   localparam logic FAST_POR_ON     = 1'b0;
   localparam logic [2:0] XIP_OFF   = 3'h7;
   localparam logic [15:0] NVCR_DELIVERED   = 16'hFFFF;
   localparam logic [7:0]  STATUS_DELIVERED = 8'h00;
   localparam logic [7:0]  ARRAY_ERASED     = 8'hFF;
   localparam logic [1:0]  LOCK_AFTER_POR   = 2'h0;
   localparam int STAT_WIP_BIT   = 0;
   localparam int STAT_WEL_BIT   = 1;
   localparam int FLAG_READY_BIT = 7;

   typedef enum logic [2:0] {
      KIND_POLL_STATUS = 3'h0,
      KIND_POLL_FLAG   = 3'h1,
      KIND_WRITE_EN    = 3'h2,
      KIND_WRITE_NVCR  = 3'h3,
      KIND_WRITE_VCR   = 3'h4,
      KIND_READ        = 3'h5,
      KIND_RESCUE      = 3'h6
   } fpr_kind_type;

endpackage : fpr_pkg

//--- src/fpr_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fpr_link_if;
   logic sel_n;
   logic sclk;
   logic io_lane_zero;
   logic io_lane_three;
   logic io1_o;
   logic io1_oe_n;
   logic io1;

   // Lane one idles high when the device does not drive it
   assign io1 = io1_oe_n ? 1'b1 : io1_o;

   modport dev (
      input  sel_n, sclk, io_lane_zero, io_lane_three,
      output io1_o, io1_oe_n
   );
   modport host (
      output sel_n, sclk, io_lane_zero, io_lane_three,
      input  io1
   );
endinterface : fpr_link_if

`default_nettype wire

//--- src/fpr_device_end.sv
// What this block does
// - Standard boot accepts only status polling commands
// - After boot: standby, write enable, busy cleared
// - Sector lock bits come up as zero
// - Power-on reset silences device completely
// - Quick boot allows reads within 100 us
// - First write enable starts 500 us phase
// - Phase sets both bits, ends keeping enable
// - Quick boot chosen by config bit five
// - Standard boot fully accessible by 600 us
// - Quick boot write-ready by 500 us phase
// - Lane zero 7,13,25 clocks exits execute-in-place
// - Lanes zero, three 8 clocks force single-lane
// - Host keeps 50 ns deselect between selections
// - Forced single-lane holds until next power-up
// - Host should rewrite nonvolatile config afterwards
// - Delivered: array erased, status all zero
// - Host keeps deselected while supply moves
// - Execute-in-place exit resets nothing else
`timescale 1ns/1ps
`default_nettype none

module fpr_device_end
   import fpr_pkg::*;
#(
   parameter int VTR_CYCLES = VTR_CYC,
   parameter int DTW_CYCLES = DTW_CYC,
   parameter int VTW_CYCLES = VTW_CYC
) (
   // Internal clock and power-on reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Serial link
   fpr_link_if.dev          link,
   // Nonvolatile and volatile configuration stores
   input  wire logic [15:0] i_nvcr_stored,
   output var  logic        o_nvcr_wr,
   output var  logic [15:0] o_nvcr_wdata,
   output var  logic        o_vcr_wr,
   output var  logic [7:0]  o_vcr_wdata,
   // Device state
   output var  logic        o_wel,
   output var  logic        o_wip,
   output var  logic        o_xip,
   output var  logic        o_std_forced,
   output var  logic        o_ready,
   output var  logic [1:0]  o_sector_lock
);

   typedef enum logic [5:0] {
      ST_CAPTURE = 6'b00_0001,
      ST_BOOT    = 6'b00_0010,
      ST_QBOOT   = 6'b00_0100,
      ST_LIMITED = 6'b00_1000,
      ST_PHASE2  = 6'b01_0000,
      ST_READY   = 6'b10_0000
   } fpr_pwr_type;

   typedef struct packed {
      logic [5:0]  cnt;
      logic        ones0;
      logic        ones03;
      logic [23:0] sr;
      logic [7:0]  op;
      logic        out;
      logic        oe_n;
      logic [17:0] s1;
      logic [17:0] s2;
   } fpr_lnk_type;

   typedef struct packed {
      logic        sel_s1;
      logic        sel_s2;
      logic        sel_d;
      fpr_pwr_type st;
      logic [19:0] cnt;
      logic        write_enable_latch;
      logic        write_in_progress;
      logic        xip;
      logic        std_forced;
      logic [1:0]  stage;
      logic        nvcr_wr;
      logic [15:0] nvcr_wdata;
      logic        vcr_wr;
      logic [7:0]  vcr_wdata;
      logic [1:0]  lock;
      logic [17:0] mirror;
   } fpr_dev_type;

   fpr_lnk_type lnk_ff, nxt_lnk;
   fpr_dev_type dev_ff, nxt_dev;
   logic        frame_new_ff;
   logic [7:0]  op_now;
   logic [2:0]  bit_idx;

   function automatic logic [19:0] cyc(input int n);
      return 20'(n - 1);
   endfunction : cyc

   // Marks the first link edge of each selection
   always_ff @(posedge link.sclk or posedge link.sel_n or negedge i_rst_n)
   begin
      if (!i_rst_n) begin
         frame_new_ff <= 1'b1;
      end else if (link.sel_n) begin
         frame_new_ff <= 1'b1;
      end else begin
         frame_new_ff <= 1'b0;
      end
   end

   // Link side: shifts lane zero, counts clocks, answers reads
   always_comb begin
      nxt_lnk    = lnk_ff;
      nxt_lnk.s1 = dev_ff.mirror;
      nxt_lnk.s2 = lnk_ff.s1;
      if (frame_new_ff) begin
         nxt_lnk.cnt    = 6'h01;
         nxt_lnk.ones0  = link.io_lane_zero;
         nxt_lnk.ones03 = link.io_lane_zero & link.io_lane_three;
         nxt_lnk.sr     = {23'h00_0000, link.io_lane_zero};
         nxt_lnk.op     = 8'h00;
      end else begin
         nxt_lnk.cnt    = (lnk_ff.cnt == 6'h3F) ? lnk_ff.cnt
                                                : lnk_ff.cnt + 6'h01;
         nxt_lnk.ones0  = lnk_ff.ones0 & link.io_lane_zero;
         nxt_lnk.ones03 = lnk_ff.ones03 & link.io_lane_zero
                          & link.io_lane_three;
         nxt_lnk.sr     = {lnk_ff.sr[22:0], link.io_lane_zero};
      end
      op_now = lnk_ff.op;
      if (!frame_new_ff && nxt_lnk.cnt == 6'(LEN_CMD)) begin
         op_now = {lnk_ff.sr[6:0], link.io_lane_zero};
      end
      nxt_lnk.op   = op_now;
      bit_idx      = 3'(nxt_lnk.cnt - 6'(LEN_CMD));
      nxt_lnk.out  = 1'b1;
      nxt_lnk.oe_n = 1'b1;
      if (nxt_lnk.cnt >= 6'(LEN_CMD) && !lnk_ff.s2[16]) begin
         if (op_now == OP_READ_STATUS) begin
            nxt_lnk.out  = lnk_ff.s2[8 + 7 - bit_idx];
            nxt_lnk.oe_n = 1'b0;
         end else if (op_now == OP_READ_FLAG) begin
            nxt_lnk.out  = lnk_ff.s2[7 - bit_idx];
            nxt_lnk.oe_n = 1'b0;
         end else if (op_now == OP_READ && lnk_ff.s2[17]
                      && nxt_lnk.cnt >= 6'(LEN_RD_DATA)) begin
            nxt_lnk.out  = ARRAY_ERASED[7 - bit_idx];
            nxt_lnk.oe_n = 1'b0;
         end
      end
   end

   always_ff @(posedge link.sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lnk_ff <= '{oe_n: 1'b1, out: 1'b1, default: '0};
      end else begin
         lnk_ff <= nxt_lnk;
      end
   end

   // Internal clock side: power sequence, rescue, command effects
   always_comb begin
      logic desel;
      logic [5:0] n;
      nxt_dev         = dev_ff;
      desel           = 1'b0;
      n               = lnk_ff.cnt;
      nxt_dev.sel_s1  = link.sel_n;
      nxt_dev.sel_s2  = dev_ff.sel_s1;
      nxt_dev.sel_d   = dev_ff.sel_s2;
      nxt_dev.nvcr_wr = 1'b0;
      nxt_dev.vcr_wr  = 1'b0;
      nxt_dev.cnt     = dev_ff.cnt + 20'h0_0001;
      unique case (dev_ff.st)
         ST_CAPTURE: begin
            nxt_dev.cnt = 20'h0_0000;
            nxt_dev.xip = (i_nvcr_stored[NVCR_XIP_MSB:NVCR_XIP_LSB]
                           != XIP_OFF) && !dev_ff.std_forced;
            if (i_nvcr_stored[NVCR_FAST_POR_BIT] == FAST_POR_ON) begin
               nxt_dev.st = ST_QBOOT;
            end else begin
               nxt_dev.st = ST_BOOT;
            end
         end
         ST_BOOT: begin
            if (dev_ff.cnt == cyc(VTW_CYCLES)) begin
               nxt_dev.st = ST_READY;
            end
         end
         ST_QBOOT: begin
            if (dev_ff.cnt == cyc(VTR_CYCLES)) begin
               nxt_dev.st = ST_LIMITED;
            end
         end
         ST_PHASE2: begin
            if (dev_ff.cnt == cyc(DTW_CYCLES)) begin
               nxt_dev.st  = ST_READY;
               nxt_dev.write_in_progress = 1'b0;
            end
         end
         default: begin
            nxt_dev.cnt = 20'h0_0000;
         end
      endcase
      // Link fields are stable here: no link edge while deselected
      desel = dev_ff.sel_s2 && !dev_ff.sel_d
              && dev_ff.st != ST_CAPTURE;
      if (desel) begin
         if (dev_ff.stage == 2'h3 && n == 6'(LEN_RESCUE3)
             && lnk_ff.ones03) begin
            nxt_dev.stage      = 2'h0;
            nxt_dev.std_forced = 1'b1;
         end else if (dev_ff.stage == 2'h2 && n == 6'(LEN_RESCUE2)
                      && lnk_ff.ones0) begin
            nxt_dev.stage = 2'h3;
            nxt_dev.xip   = 1'b0;
         end else if (dev_ff.stage == 2'h1 && n == 6'(LEN_RESCUE1)
                      && lnk_ff.ones0) begin
            nxt_dev.stage = 2'h2;
         end else if (n == 6'(LEN_RESCUE0) && lnk_ff.ones0) begin
            nxt_dev.stage = 2'h1;
         end else begin
            nxt_dev.stage = 2'h0;
            if (!dev_ff.xip && n == 6'(LEN_CMD)
                && lnk_ff.op == OP_WRITE_EN) begin
               if (dev_ff.st == ST_READY) begin
                  nxt_dev.write_enable_latch = 1'b1;
               end else if (dev_ff.st == ST_LIMITED) begin
                  nxt_dev.st  = ST_PHASE2;
                  nxt_dev.cnt = 20'h0_0000;
                  nxt_dev.write_enable_latch = 1'b1;
                  nxt_dev.write_in_progress = 1'b1;
               end
            end
            if (!dev_ff.xip && n == 6'(LEN_NVCR)
                && lnk_ff.op == OP_WRITE_NVCR
                && dev_ff.st == ST_READY && dev_ff.write_enable_latch) begin
               nxt_dev.nvcr_wr    = 1'b1;
               nxt_dev.nvcr_wdata = lnk_ff.sr[15:0];
               nxt_dev.write_enable_latch        = 1'b0;
            end
            if (!dev_ff.xip && n == 6'(LEN_VCR)
                && lnk_ff.op == OP_WRITE_VCR
                && (dev_ff.st == ST_READY
                    || dev_ff.st == ST_LIMITED)) begin
               nxt_dev.vcr_wr    = 1'b1;
               nxt_dev.vcr_wdata = lnk_ff.sr[7:0];
            end
         end
      end
      nxt_dev.mirror = {(nxt_dev.st == ST_READY
                         || nxt_dev.st == ST_LIMITED),
                        nxt_dev.xip,
                        6'h00, nxt_dev.write_enable_latch, nxt_dev.write_in_progress,
                        !nxt_dev.write_in_progress, 7'h00};
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dev_ff <= '{st: ST_CAPTURE, sel_s1: 1'b1, sel_s2: 1'b1,
                     sel_d: 1'b1, lock: LOCK_AFTER_POR,
                     mirror: {2'h0, STATUS_DELIVERED, 8'h00},
                     default: '0};
      end else begin
         dev_ff <= nxt_dev;
      end
   end

   assign link.io1_o    = lnk_ff.out;
   assign link.io1_oe_n = lnk_ff.oe_n;
   assign o_nvcr_wr     = dev_ff.nvcr_wr;
   assign o_nvcr_wdata  = dev_ff.nvcr_wdata;
   assign o_vcr_wr      = dev_ff.vcr_wr;
   assign o_vcr_wdata   = dev_ff.vcr_wdata;
   assign o_wel         = dev_ff.write_enable_latch;
   assign o_wip         = dev_ff.write_in_progress;
   assign o_xip         = dev_ff.xip;
   assign o_std_forced  = dev_ff.std_forced;
   // Ready is the one-hot bit of the ready state, read straight off the flop
   assign o_ready       = dev_ff.st[5];
   assign o_sector_lock = dev_ff.lock;

endmodule : fpr_device_end

`default_nettype wire

//--- src/fpr_host_end.sv
`timescale 1ns/1ps
`default_nettype none

module fpr_host_end
   import fpr_pkg::*;
(
   // Clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_rst_n,
   // Serial link
   fpr_link_if.host          link,
   // Request port
   input  wire logic         i_req_valid,
   input  wire fpr_kind_type i_req_kind,
   input  wire logic [15:0]  i_req_data,
   output var  logic         o_req_ready,
   output var  logic         o_done,
   output var  logic [7:0]   o_rdata
);

   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_LOW  = 4'b0010,
      HS_HIGH = 4'b0100,
      HS_GAP  = 4'b1000
   } fpr_hst_type;

   typedef struct packed {
      fpr_hst_type st;
      logic [4:0]  div;
      logic [5:0]  left;
      logic [39:0] tx;
      logic [7:0]  rx;
      logic        rescue;
      logic [1:0]  part;
      logic        sel_n;
      logic        sclk;
      logic        io0;
      logic        io1_s1;
      logic        io1_s2;
      logic        ready;
      logic        done;
   } fpr_host_type;

   fpr_host_type h_ff, nxt_h;

   function automatic logic [5:0] rescue_len(input logic [1:0] p);
      unique case (p)
         2'h0:    return 6'(LEN_RESCUE0);
         2'h1:    return 6'(LEN_RESCUE1);
         2'h2:    return 6'(LEN_RESCUE2);
         default: return 6'(LEN_RESCUE3);
      endcase
   endfunction : rescue_len

   always_comb begin
      nxt_h        = h_ff;
      nxt_h.io1_s1 = link.io1;
      nxt_h.io1_s2 = h_ff.io1_s1;
      nxt_h.done   = 1'b0;
      nxt_h.div    = h_ff.div - 5'h01;
      unique case (h_ff.st)
         HS_IDLE: begin
            nxt_h.div = 5'(SCLK_HALF - 1);
            if (i_req_valid) begin
               nxt_h.ready  = 1'b0;
               nxt_h.sel_n  = 1'b0;
               nxt_h.st     = HS_LOW;
               nxt_h.rescue = 1'b0;
               nxt_h.part   = 2'h0;
               unique case (i_req_kind)
                  KIND_POLL_STATUS: begin
                     nxt_h.tx   = {OP_READ_STATUS, 32'h0000_0000};
                     nxt_h.left = 6'(LEN_POLL);
                  end
                  KIND_POLL_FLAG: begin
                     nxt_h.tx   = {OP_READ_FLAG, 32'h0000_0000};
                     nxt_h.left = 6'(LEN_POLL);
                  end
                  KIND_WRITE_EN: begin
                     nxt_h.tx   = {OP_WRITE_EN, 32'h0000_0000};
                     nxt_h.left = 6'(LEN_CMD);
                  end
                  KIND_WRITE_NVCR: begin
                     nxt_h.tx   = {OP_WRITE_NVCR, i_req_data,
                                   16'h0000};
                     nxt_h.left = 6'(LEN_NVCR);
                  end
                  KIND_WRITE_VCR: begin
                     nxt_h.tx   = {OP_WRITE_VCR, i_req_data[7:0],
                                   24'h00_0000};
                     nxt_h.left = 6'(LEN_VCR);
                  end
                  KIND_READ: begin
                     nxt_h.tx   = {OP_READ, i_req_data, 16'h0000};
                     nxt_h.left = 6'(LEN_READ);
                  end
                  default: begin
                     nxt_h.tx     = {40{1'b1}};
                     nxt_h.left   = rescue_len(2'h0);
                     nxt_h.rescue = 1'b1;
                  end
               endcase
               nxt_h.io0 = nxt_h.tx[39];
            end
         end
         HS_LOW: begin
            if (h_ff.div == 5'h00) begin
               nxt_h.sclk = 1'b1;
               nxt_h.rx   = {h_ff.rx[6:0], h_ff.io1_s2};
               nxt_h.div  = 5'(SCLK_HALF - 1);
               nxt_h.st   = HS_HIGH;
            end
         end
         HS_HIGH: begin
            if (h_ff.div == 5'h00) begin
               nxt_h.sclk = 1'b0;
               nxt_h.tx   = {h_ff.tx[38:0], h_ff.rescue};
               nxt_h.io0  = h_ff.tx[38];
               nxt_h.left = h_ff.left - 6'h01;
               nxt_h.div  = 5'(SCLK_HALF - 1);
               nxt_h.st   = HS_LOW;
               if (h_ff.left == 6'h01) begin
                  nxt_h.sel_n = 1'b1;
                  nxt_h.div   = 5'(DESEL_CYC - 1);
                  nxt_h.st    = HS_GAP;
               end
            end
         end
         HS_GAP: begin
            if (h_ff.div == 5'h00) begin
               if (h_ff.rescue && h_ff.part != 2'h3) begin
                  nxt_h.part  = h_ff.part + 2'h1;
                  nxt_h.left  = rescue_len(nxt_h.part);
                  nxt_h.tx    = {40{1'b1}};
                  nxt_h.io0   = 1'b1;
                  nxt_h.sel_n = 1'b0;
                  nxt_h.div   = 5'(SCLK_HALF - 1);
                  nxt_h.st    = HS_LOW;
               end else begin
                  nxt_h.io0   = 1'b0;
                  nxt_h.done  = 1'b1;
                  nxt_h.ready = 1'b1;
                  nxt_h.st    = HS_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         h_ff <= '{st: HS_IDLE, sel_n: 1'b1, io1_s1: 1'b1,
                   io1_s2: 1'b1, ready: 1'b1, default: '0};
      end else begin
         h_ff <= nxt_h;
      end
   end

   assign link.sel_n         = h_ff.sel_n;
   assign link.sclk          = h_ff.sclk;
   assign link.io_lane_zero  = h_ff.io0;
   assign link.io_lane_three = 1'b1;
   assign o_req_ready        = h_ff.ready;
   assign o_done             = h_ff.done;
   assign o_rdata            = h_ff.rx;

endmodule : fpr_host_end

`default_nettype wire

//--- verification/fpr_link_properties.sv
`timescale 1ns/1ps
`default_nettype none

module fpr_link_properties
   import fpr_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Link
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic io_lane_zero,
   input wire logic io_lane_three,
   input wire logic io1_oe_n
);
   logic [5:0] sel_hi;
   logic [5:0] clk_cnt;
   logic [4:0] hi_cnt;
   logic [7:0] cmd_sr;
   logic       sclk_q;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_hi  <= 6'h3F;
         clk_cnt <= 6'h00;
         hi_cnt  <= 5'h00;
         cmd_sr  <= 8'h00;
         sclk_q  <= 1'h0;
      end else begin
         sclk_q <= sclk;
         hi_cnt <= sclk ? hi_cnt + 5'h01 : 5'h00;
         if (!sel_n) begin
            sel_hi <= 6'h00;
         end else if (sel_hi != 6'h3F) begin
            sel_hi <= sel_hi + 6'h01;
         end
         if (sel_n) begin
            clk_cnt <= 6'h00;
         end else if (sclk && !sclk_q) begin
            clk_cnt <= clk_cnt + 6'h01;
            if (clk_cnt < 6'h08) begin
               cmd_sr <= {cmd_sr[6:0], io_lane_zero};
            end
         end
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   // Eighth clock of a status or flag poll
   sequence s_poll_head;
      $rose(clk_cnt == 6'h08) && !sel_n &&
         (cmd_sr == OP_READ_STATUS || cmd_sr == OP_READ_FLAG);
   endsequence
   sequence s_frame_end;
      $rose(sel_n);
   endsequence

   a_reset_quiet: assert property (disable iff (1'h0)
      !i_rst_n |-> io1_oe_n) else $error("lane one driven in reset");
   a_reset_desel: assert property (disable iff (1'h0)
      !i_rst_n |-> sel_n) else $error("selected during reset");
   a_desel_gap: assert property (
      $fell(sel_n) |-> sel_hi >= 6'(DESEL_CYC))
      else $error("deselect gap too short");
   a_frame_len: assert property (
      s_frame_end |-> clk_cnt inside {LEN_CMD, LEN_POLL, LEN_NVCR,
         LEN_READ, LEN_RESCUE0, LEN_RESCUE1, LEN_RESCUE2})
      else $error("frame clock count illegal");
   a_hold_high: assert property (
      io_lane_three) else $error("lane three not held high");
   a_poll_answer: assert property (
      s_poll_head |-> ##[0:2] !io1_oe_n) else $error("poll not answered");
   a_data_stable: assert property (
      !sel_n && sclk && $past(sclk) |-> $stable(io_lane_zero))
      else $error("lane zero moved while clock high");
   a_sclk_width: assert property (
      $fell(sclk) |-> hi_cnt == 5'(SCLK_HALF))
      else $error("link clock high time wrong");
endmodule : fpr_link_properties

`default_nettype wire

//--- verification/test_flash_power_on_and_rescue.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
   begin \
      n_tests++; \
      if ((a) !== (b)) begin \
         err_count++; \
         $display("[ERR] %0t got 0x%h exp 0x%h", $time, (a), (b)); \
      end \
   end

module test_flash_power_on_and_rescue
   import fpr_pkg::*;
;
   localparam int VTR_T = 1000;
   localparam int DTW_T = 2000;
   localparam int VTW_T = 2400;

   typedef struct packed {
      fpr_kind_type kind;
      logic [15:0]  data;
      logic         chk;
      logic [7:0]   rd;
      logic         latch;
   } fpr_row_type;

   localparam fpr_row_type ROWS [8] = '{
      '{KIND_POLL_STATUS, 16'h0000, 1'h1, 8'h00, 1'h0},
      '{KIND_POLL_FLAG,   16'h0000, 1'h1, 8'h80, 1'h0},
      '{KIND_WRITE_EN,    16'h0000, 1'h0, 8'h00, 1'h1},
      '{KIND_POLL_STATUS, 16'h0000, 1'h1, 8'h02, 1'h1},
      '{KIND_WRITE_VCR,   16'h00A5, 1'h0, 8'h00, 1'h1},
      '{KIND_WRITE_NVCR,  16'hFFDF, 1'h0, 8'h00, 1'h0},
      '{KIND_READ,        16'h0010, 1'h1, 8'hFF, 1'h0},
      '{KIND_POLL_FLAG,   16'h0000, 1'h1, 8'h80, 1'h0}
   };

   logic         i_mclk;
   logic         i_rst_n;
   logic         req_valid;
   fpr_kind_type req_kind;
   logic [15:0]  req_data;
   logic [15:0]  nvcr;
   logic         nvcr_wr;
   logic [15:0]  nvcr_wdata;
   logic         vcr_wr;
   logic [7:0]   vcr_wdata;
   logic         wr_en_latch;
   logic         busy;
   logic         xip;
   logic         std_forced;
   logic         ready;
   logic [1:0]   sector_lock;
   logic         req_ready;
   logic         done;
   logic [7:0]   rdata;
   int           err_count;
   int           n_tests;
   int           cyc;
   int           n;
   int           rel;
   int           drv0;
   int           n_drv;
   int           n_vcr;
   int           n_nvcr;

   fpr_link_if fpr_link_if_i ();

   fpr_device_end #(
      .VTR_CYCLES (VTR_T),
      .DTW_CYCLES (DTW_T),
      .VTW_CYCLES (VTW_T)
   ) fpr_device_end_i (
      .i_mclk        (i_mclk),
      .i_rst_n       (i_rst_n),
      .link          (fpr_link_if_i),
      .i_nvcr_stored (nvcr),
      .o_nvcr_wr     (nvcr_wr),
      .o_nvcr_wdata  (nvcr_wdata),
      .o_vcr_wr      (vcr_wr),
      .o_vcr_wdata   (vcr_wdata),
      .o_wel         (wr_en_latch),
      .o_wip         (busy),
      .o_xip         (xip),
      .o_std_forced  (std_forced),
      .o_ready       (ready),
      .o_sector_lock (sector_lock)
   );

   fpr_host_end fpr_host_end_i (
      .i_mclk      (i_mclk),
      .i_rst_n     (i_rst_n),
      .link        (fpr_link_if_i),
      .i_req_valid (req_valid),
      .i_req_kind  (req_kind),
      .i_req_data  (req_data),
      .o_req_ready (req_ready),
      .o_done      (done),
      .o_rdata     (rdata)
   );

   fpr_link_properties fpr_link_properties_i (
      .i_mclk        (i_mclk),
      .i_rst_n       (i_rst_n),
      .sel_n         (fpr_link_if_i.sel_n),
      .sclk          (fpr_link_if_i.sclk),
      .io_lane_zero  (fpr_link_if_i.io_lane_zero),
      .io_lane_three (fpr_link_if_i.io_lane_three),
      .io1_oe_n      (fpr_link_if_i.io1_oe_n)
   );

   initial i_mclk = 1'h0;
   always #2.5 i_mclk = ~i_mclk;

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         final_report();
      end
   end

   // Counts cycles with lane one driven and write pulses seen
   always @(posedge i_mclk) begin
      if (fpr_link_if_i.io1_oe_n === 1'h0) n_drv++;
      if (vcr_wr === 1'h1) n_vcr++;
      if (nvcr_wr === 1'h1) n_nvcr++;
   end

   task automatic do_req(input fpr_kind_type k, input logic [15:0] d);
      int w;
      w = 0;
      @(posedge i_mclk);
      req_valid <= 1'h1;
      req_kind  <= k;
      req_data  <= d;
      @(posedge i_mclk);
      req_valid <= 1'h0;
      while (done !== 1'h1 && w < 5000) begin
         @(posedge i_mclk);
         w++;
      end
      `CHK({done, req_ready}, 2'h3)
      repeat (2) @(posedge i_mclk);
   endtask : do_req

   task automatic power_up(input logic [15:0] nv);
      @(posedge i_mclk);
      i_rst_n <= 1'h0;
      nvcr    <= nv;
      repeat (16) @(posedge i_mclk);
      `CHK({wr_en_latch, busy, xip, std_forced, ready}, 5'h00)
      `CHK(sector_lock, LOCK_AFTER_POR)
      `CHK(fpr_link_if_i.sel_n, 1'h1)
      i_rst_n <= 1'h1;
      rel = cyc;
   endtask : power_up

   initial begin
      // Reset falls at the first edge, once every process is waiting
      i_rst_n   = 1'h1;
      req_valid = 1'h0;
      req_kind  = KIND_POLL_STATUS;
      req_data  = 16'h0000;
      nvcr      = NVCR_DELIVERED;
      power_up(NVCR_DELIVERED);
      do_req(KIND_POLL_STATUS, 16'h0000);
      `CHK({rdata, ready}, 9'h000)
      do_req(KIND_WRITE_EN, 16'h0000);
      `CHK(wr_en_latch, 1'h0)
      drv0 = n_drv;
      do_req(KIND_READ, 16'h0000);
      `CHK({rdata, n_drv == drv0}, 9'h1FF)
      n = 0;
      while (ready !== 1'h1 && n < VTW_T) begin
         @(posedge i_mclk);
         n++;
      end
      `CHK(cyc - rel <= VTW_T + 2, 1'h1)
      `CHK({wr_en_latch, busy, sector_lock}, 4'h0)
      for (int i = 0; i < 8; i++) begin
         do_req(ROWS[i].kind, ROWS[i].data);
         if (ROWS[i].chk) `CHK(rdata, ROWS[i].rd)
         `CHK(wr_en_latch, ROWS[i].latch)
      end
      `CHK({vcr_wdata, nvcr_wdata}, 24'hA5_FFDF)
      $display("test standard boot done");
      power_up(16'hFFDF);
      do_req(KIND_WRITE_VCR, 16'h0033);
      `CHK(vcr_wdata, 8'h00)
      repeat (VTR_T) @(posedge i_mclk);
      drv0 = n_drv;
      do_req(KIND_READ, 16'h0100);
      `CHK(rdata, ARRAY_ERASED)
      `CHK(n_drv != drv0, 1'h1)
      do_req(KIND_WRITE_VCR, 16'h005A);
      `CHK({vcr_wdata, ready}, 9'h0B4)
      do_req(KIND_WRITE_EN, 16'h0000);
      `CHK({wr_en_latch, busy}, 2'h3)
      do_req(KIND_POLL_STATUS, 16'h0000);
      `CHK(rdata, 8'h03)
      do_req(KIND_WRITE_VCR, 16'h0066);
      `CHK(vcr_wdata, 8'h5A)
      n = 0;
      while (busy !== 1'h0 && n < DTW_T) begin
         @(posedge i_mclk);
         n++;
      end
      `CHK({wr_en_latch, busy, ready}, 3'h5)
      $display("test quick boot done");
      power_up(16'hF1FF);
      repeat (VTW_T + 20) @(posedge i_mclk);
      `CHK(xip, 1'h1)
      do_req(KIND_RESCUE, 16'h0000);
      `CHK({xip, std_forced, sector_lock}, 4'h4)
      do_req(KIND_WRITE_EN, 16'h0000);
      do_req(KIND_WRITE_NVCR, NVCR_DELIVERED);
      `CHK({std_forced, nvcr_wdata}, 17'h1_FFFF)
      do_req(KIND_POLL_STATUS, 16'h0000);
      `CHK(rdata, STATUS_DELIVERED)
      `CHK(n_vcr, 32'h0000_0002)
      `CHK(n_nvcr, 32'h0000_0002)
      power_up(NVCR_DELIVERED);
      $display("test rescue done");
      final_report();
   end
endmodule : test_flash_power_on_and_rescue

`undef CHK
`default_nettype wire
